// *** core/wpid_regs.vh ***
/*
 Register offsets, field positions, reset values and codes of the winder PID output-shaping block.
 Assumes 8-bit APB byte addresses and percent values in units of 0.01 %.
*/
`ifndef WPID_REGS_VH
`define WPID_REGS_VH

`define WPID_ADDR_CONFIG   8'h00
`define WPID_ADDR_DISPLAY  8'h04
`define WPID_ADDR_SETPOINT 8'h08
`define WPID_ADDR_WCTRL    8'h0C
`define WPID_ADDR_CLAMP    8'h10
`define WPID_ADDR_GAIN     8'h14
`define WPID_ADDR_LSRANGE  8'h18
`define WPID_ADDR_KGAIN    8'h1C
`define WPID_ADDR_DIFUNC   8'h20
`define WPID_ADDR_ERR      8'h24
`define WPID_ADDR_PIDOUT   8'h28
`define WPID_ADDR_CLAMPED  8'h2C
`define WPID_ADDR_SCALED   8'h30
`define WPID_ADDR_FREQ     8'h34

`define WPID_CFG_SPEED_OL  3'h0
`define WPID_CFG_SPEED_CL  3'h1
`define WPID_CFG_PROC_STD  3'h2
`define WPID_CFG_WINDER    3'h3
`define WPID_CFG_TORQUE_OL 3'h4
`define WPID_CFG_TORQUE_FB 3'h5

`define WPID_WCTRL_ICLR    0
`define WPID_WCTRL_REFINV  1
`define WPID_WCTRL_ERRINV  2
`define WPID_WCTRL_SFE     3
`define WPID_CLAMP_NEG_EN  15
`define WPID_CLAMP_POS_EN  31

`define WPID_RST_SLOT1     5'h00
`define WPID_RST_SLOT2     5'h00
`define WPID_RST_SLOT3     5'h07
`define WPID_FULL_SCALE    14'h2710
`define WPID_FS32          32'sh00002710
`define WPID_FS16          16'sh2710
`define WPID_RST_KP        16'h0100
`define WPID_RST_KI        16'h0010
`define WPID_KGAIN_SHIFT   8

`define WPID_DI17_RESET_I  5'h0D
`define WPID_DI19_REVERSE  2'h1
`define WPID_RST_DI17      5'h07
`define WPID_RST_DI19      2'h1

`endif

// *** core/wpid_gain.v ***
/*
 Line-speed-dependent gain scaling of the clamped controller output.
 Assumes limits in 0.01 % units, min/max scales 0..10000, results registered on core_clk.
*/
`timescale 1ns/10ps
`include "wpid_regs.vh"
module wpid_gain (
   input  wire               core_clk,
   input  wire               sys_rst,
   input  wire signed [15:0] line_speed,
   input  wire        [13:0] ls_min,
   input  wire        [13:0] ls_max,
   input  wire        [13:0] scale_min,
   input  wire        [13:0] scale_max,
   input  wire signed [15:0] x_in,
   output wire signed [15:0] y_out
);
   reg  signed [31:0] factor_ff;
   reg  signed [31:0] nxt_factor;
   reg  signed [15:0] y_ff;
   wire signed [31:0] ls32  = {{16{line_speed[15]}}, line_speed};
   wire signed [31:0] lo32  = {18'h00000, ls_min};
   wire signed [31:0] hi32  = {18'h00000, ls_max};
   wire signed [31:0] smin  = {18'h00000, scale_min};
   wire signed [31:0] smax  = {18'h00000, scale_max};
   wire signed [31:0] den   = hi32 - lo32;
   // Signed product and quotient, so a negative clamped output keeps its sign
   wire signed [31:0] prod  = ($signed({{16{x_in[15]}}, x_in}) * factor_ff) / `WPID_FS32;

   function signed [15:0] sat_pct;
      input signed [31:0] v;
      begin
         if (v > `WPID_FS32)
            sat_pct = `WPID_FS16;
         else if (v < -`WPID_FS32)
            sat_pct = -`WPID_FS16;
         else
            sat_pct = v[15:0];
      end
   endfunction

   // Linear interpolation of the scale over the line speed range
   always @* begin
      if (ls32 <= lo32 || den <= 32'sh00000000)
         nxt_factor = smin;
      else if (ls32 >= hi32)
         nxt_factor = smax;
      else
         nxt_factor = smin + ((smax - smin) * (ls32 - lo32)) / den;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         factor_ff <= `WPID_FS32;
         y_ff      <= 16'sh0000;
      end else begin
         factor_ff <= nxt_factor;
         y_ff      <= sat_pct(prod);
      end
   end

   assign y_out = y_ff;
endmodule

// *** core/wpid_core.v ***
/*
 Winder PID core: configuration, error, integrator, clamps, gain scaling and line speed feed forward,
 with an APB register slave. Assumes synchronous inputs, one 100 MHz clock and a sample_tick pulse.
*/
// Behaviour
// - Three top-line display slots each hold any one of 32 data choices, same list as line two.
// - The configuration codes are 0 speed open loop, 1 speed closed loop, 3 winder process, 4 and 5 torque.
// - The setpoint and the winder control word are reachable only while the configuration is the winder process code.
// - The generic process configuration is refused; the process code engages the winder controller.
// - Entering the winder configuration presets the integral to the present output less the line speed term; leaving it sets the output to the line speed.
// - An enabled negative clamp bounds the output below at 0 to -100 % of maximum frequency.
// - An enabled positive clamp bounds the output above at 0 to 100 % of maximum frequency.
// - The clamped output is multiplied by a gain from the min and max scales, both 100 % at reset.
// - The setpoint spans -100.00 to +100.00 %, resets to zero and is the error reference.
// - Integrator reset On clears the integral term and integration resumes right after.
// - Reference inversion Off adds the line speed to the output, On subtracts it.
// - Error inversion On negates the error, Off by default.
// - Without inversion a feedback below the setpoint raises the output, with it lowers it.
// - Error inversion and the reversing input together cancel each other.
// - A digital input set to integrator reset holds the integral at zero while high.
`timescale 1ns/10ps
`include "wpid_regs.vh"
module wpid_core (
   input  wire               core_clk,
   input  wire               sys_rst,
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire        [7:0]  paddr,
   input  wire        [31:0] pwdata,
   output wire        [31:0] prdata,
   output wire               pready,
   output wire               pslverr,
   input  wire signed [15:0] feedback_in,
   input  wire signed [15:0] line_speed_in,
   input  wire               sample_tick,
   input  wire               di17_in,
   input  wire               di19_in,
   output wire signed [15:0] freq_cmd,
   output wire               winder_active,
   output wire               process_start_freq_enable,
   output wire        [4:0]  disp_slot1,
   output wire        [4:0]  disp_slot2,
   output wire        [4:0]  disp_slot3
);
   reg         [2:0]  cfg_ff;
   reg         [2:0]  cfg_prev_ff;
   reg                winder_ff;
   reg         [4:0]  slot1_ff;
   reg         [4:0]  slot2_ff;
   reg         [4:0]  slot3_ff;
   reg  signed [15:0] setpt_ff;
   reg                iclr_ff;
   reg                ref_inv_ff;
   reg                err_inv_ff;
   reg                sfe_ff;
   reg         [13:0] neg_lim_ff;
   reg                neg_en_ff;
   reg         [13:0] pos_lim_ff;
   reg                pos_en_ff;
   reg         [13:0] smin_ff;
   reg         [13:0] smax_ff;
   reg         [13:0] lsmin_ff;
   reg         [13:0] lsmax_ff;
   reg         [15:0] kp_ff;
   reg         [15:0] ki_ff;
   reg         [4:0]  di17f_ff;
   reg         [1:0]  di19f_ff;
   reg         [31:0] prdata_ff;
   reg                pready_ff;
   reg                pslverr_ff;
   reg  signed [15:0] err_ff;
   reg  signed [15:0] integ_ff;
   reg  signed [15:0] pid_ff;
   reg  signed [15:0] clamp_ff;
   reg  signed [15:0] freq_ff;
   reg         [31:0] nxt_rdata;
   reg                nxt_bad;
   reg                nxt_ro;
   reg  signed [15:0] nxt_clamp;
   wire signed [15:0] scaled;

   function signed [15:0] sat_pct;
      input signed [31:0] v;
      begin
         if (v > `WPID_FS32)
            sat_pct = `WPID_FS16;
         else if (v < -`WPID_FS32)
            sat_pct = -`WPID_FS16;
         else
            sat_pct = v[15:0];
      end
   endfunction

   // Limits above full scale are pulled back to 100 %
   function [13:0] lim_pct;
      input [13:0] v;
      begin
         if (v > `WPID_FULL_SCALE)
            lim_pct = `WPID_FULL_SCALE;
         else
            lim_pct = v;
      end
   endfunction

   function signed [31:0] sx;
      input signed [15:0] v;
      begin
         sx = {{16{v[15]}}, v};
      end
   endfunction

   // Setpoint and winder control word are gated by the present configuration
   wire win    = (cfg_ff == `WPID_CFG_WINDER);
   wire acc    = psel & penable;
   wire commit = acc & pready_ff;
   wire wr     = commit & pwrite & ~nxt_bad & ~nxt_ro;
   wire enter  = win & (cfg_prev_ff != `WPID_CFG_WINDER);

   // Register read mux and address decode
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_bad   = 1'b0;
      nxt_ro    = 1'b0;
      case (paddr)
         `WPID_ADDR_CONFIG:
            nxt_rdata = {29'h00000000, cfg_ff};
         `WPID_ADDR_DISPLAY:
            nxt_rdata = {11'h000, slot3_ff, 3'h0, slot2_ff, 3'h0, slot1_ff};
         `WPID_ADDR_SETPOINT:
            nxt_rdata = win ? sx(setpt_ff) : 32'h00000000;
         `WPID_ADDR_WCTRL:
            nxt_rdata = win ? {28'h0000000, sfe_ff, err_inv_ff, ref_inv_ff, 1'b0} : 32'h00000000;
         `WPID_ADDR_CLAMP:
            nxt_rdata = {pos_en_ff, 1'b0, pos_lim_ff, neg_en_ff, 1'b0, neg_lim_ff};
         `WPID_ADDR_GAIN:
            nxt_rdata = {2'h0, smax_ff, 2'h0, smin_ff};
         `WPID_ADDR_LSRANGE:
            nxt_rdata = {2'h0, lsmax_ff, 2'h0, lsmin_ff};
         `WPID_ADDR_KGAIN:
            nxt_rdata = {ki_ff, kp_ff};
         `WPID_ADDR_DIFUNC:
            nxt_rdata = {22'h000000, di19f_ff, 3'h0, di17f_ff};
         `WPID_ADDR_ERR: begin
            nxt_rdata = sx(err_ff);
            nxt_ro    = 1'b1;
         end
         `WPID_ADDR_PIDOUT: begin
            nxt_rdata = sx(pid_ff);
            nxt_ro    = 1'b1;
         end
         `WPID_ADDR_CLAMPED: begin
            nxt_rdata = sx(clamp_ff);
            nxt_ro    = 1'b1;
         end
         `WPID_ADDR_SCALED: begin
            nxt_rdata = sx(scaled);
            nxt_ro    = 1'b1;
         end
         `WPID_ADDR_FREQ: begin
            nxt_rdata = sx(freq_ff);
            nxt_ro    = 1'b1;
         end
         default:
            nxt_bad = 1'b1;
      endcase
   end

   // APB answer: one wait state, pready in the second access cycle
   // Writes to read-only words answer with pslverr and change nothing
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else if (acc & ~pready_ff) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= nxt_bad | (pwrite & nxt_ro);
         prdata_ff  <= pwrite ? 32'h00000000 : nxt_rdata;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Configuration and settings written by software
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_ff     <= `WPID_CFG_SPEED_OL;
         slot1_ff   <= `WPID_RST_SLOT1;
         slot2_ff   <= `WPID_RST_SLOT2;
         slot3_ff   <= `WPID_RST_SLOT3;
         setpt_ff   <= 16'sh0000;
         iclr_ff    <= 1'b0;
         ref_inv_ff <= 1'b0;
         err_inv_ff <= 1'b0;
         sfe_ff     <= 1'b0;
         neg_lim_ff <= `WPID_FULL_SCALE;
         neg_en_ff  <= 1'b0;
         pos_lim_ff <= `WPID_FULL_SCALE;
         pos_en_ff  <= 1'b0;
         smin_ff    <= `WPID_FULL_SCALE;
         smax_ff    <= `WPID_FULL_SCALE;
         lsmin_ff   <= 14'h0000;
         lsmax_ff   <= `WPID_FULL_SCALE;
         kp_ff      <= `WPID_RST_KP;
         ki_ff      <= `WPID_RST_KI;
         di17f_ff   <= `WPID_RST_DI17;
         di19f_ff   <= `WPID_RST_DI19;
      end else begin
         iclr_ff <= 1'b0;
         if (wr) begin
            case (paddr)
               `WPID_ADDR_CONFIG: begin
                  case (pwdata[2:0])
                     `WPID_CFG_SPEED_OL, `WPID_CFG_SPEED_CL, `WPID_CFG_WINDER,
                     `WPID_CFG_TORQUE_OL, `WPID_CFG_TORQUE_FB:
                        cfg_ff <= pwdata[2:0];
                     default:
                        cfg_ff <= cfg_ff;
                  endcase
               end
               `WPID_ADDR_DISPLAY: begin
                  slot1_ff <= pwdata[4:0];
                  slot2_ff <= pwdata[12:8];
                  slot3_ff <= pwdata[20:16];
               end
               `WPID_ADDR_SETPOINT:
                  if (win)
                     setpt_ff <= sat_pct(pwdata);
               `WPID_ADDR_WCTRL:
                  if (win) begin
                     iclr_ff    <= pwdata[`WPID_WCTRL_ICLR];
                     ref_inv_ff <= pwdata[`WPID_WCTRL_REFINV];
                     err_inv_ff <= pwdata[`WPID_WCTRL_ERRINV];
                     sfe_ff     <= pwdata[`WPID_WCTRL_SFE];
                  end
               `WPID_ADDR_CLAMP: begin
                  neg_lim_ff <= lim_pct(pwdata[13:0]);
                  neg_en_ff  <= pwdata[`WPID_CLAMP_NEG_EN];
                  pos_lim_ff <= lim_pct(pwdata[29:16]);
                  pos_en_ff  <= pwdata[`WPID_CLAMP_POS_EN];
               end
               `WPID_ADDR_GAIN: begin
                  smin_ff <= lim_pct(pwdata[13:0]);
                  smax_ff <= lim_pct(pwdata[29:16]);
               end
               `WPID_ADDR_LSRANGE: begin
                  lsmin_ff <= lim_pct(pwdata[13:0]);
                  lsmax_ff <= lim_pct(pwdata[29:16]);
               end
               `WPID_ADDR_KGAIN: begin
                  kp_ff <= pwdata[15:0];
                  ki_ff <= pwdata[31:16];
               end
               `WPID_ADDR_DIFUNC: begin
                  di17f_ff <= pwdata[4:0];
                  di19f_ff <= pwdata[9:8];
               end
               default:
                  cfg_ff <= cfg_ff;
            endcase
         end
      end
   end

   // Error: setpoint minus feedback, optionally inverted
   wire        rev19   = (di19f_ff == `WPID_DI19_REVERSE) & di19_in;
   wire        inv     = err_inv_ff ^ rev19;
   wire signed [31:0] raw_err = sx(setpt_ff) - sx(feedback_in);
   wire        irst    = iclr_ff | ((di17f_ff == `WPID_DI17_RESET_I) & di17_in);
   wire signed [31:0] ls_term = ref_inv_ff ? -sx(line_speed_in) : sx(line_speed_in);
   wire signed [33:0] p_prod  = $signed({2'b00, kp_ff}) * sx(err_ff);
   wire signed [33:0] i_prod  = $signed({2'b00, ki_ff}) * sx(err_ff);
   wire signed [33:0] p_sh    = p_prod >>> `WPID_KGAIN_SHIFT;
   wire signed [33:0] i_sh    = i_prod >>> `WPID_KGAIN_SHIFT;
   wire signed [15:0] neg_b   = -$signed({2'b00, neg_lim_ff});
   wire signed [15:0] pos_b   = $signed({2'b00, pos_lim_ff});

   // Clamps act on the PID output before scaling
   always @* begin
      nxt_clamp = pid_ff;
      if (neg_en_ff && pid_ff < neg_b)
         nxt_clamp = neg_b;
      if (pos_en_ff && pid_ff > pos_b)
         nxt_clamp = pos_b;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_prev_ff <= `WPID_CFG_SPEED_OL;
         winder_ff   <= 1'b0;
         err_ff      <= 16'sh0000;
         integ_ff    <= 16'sh0000;
         pid_ff      <= 16'sh0000;
         clamp_ff    <= 16'sh0000;
         freq_ff     <= 16'sh0000;
      end else begin
         cfg_prev_ff <= cfg_ff;
         winder_ff   <= win;
         err_ff      <= inv ? sat_pct(-raw_err) : sat_pct(raw_err);
         if (irst)
            integ_ff <= 16'sh0000;
         else if (enter)
            integ_ff <= sat_pct(sx(freq_ff) - ls_term);
         else if (win && sample_tick)
            integ_ff <= sat_pct(sx(integ_ff) + i_sh[31:0]);
         pid_ff   <= sat_pct(p_sh[31:0] + sx(integ_ff));
         clamp_ff <= nxt_clamp;
         if (win)
            freq_ff <= sat_pct(sx(scaled) + ls_term);
         else
            freq_ff <= line_speed_in;
      end
   end

   // Gain stage adds one cycle to the clamped output; the line speed factor is registered a cycle ahead of the product
   wpid_gain u_gain (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .line_speed (line_speed_in),
      .ls_min     (lsmin_ff),
      .ls_max     (lsmax_ff),
      .scale_min  (smin_ff),
      .scale_max  (smax_ff),
      .x_in       (clamp_ff),
      .y_out      (scaled)
   );

   // Every port comes straight from a flip-flop
   assign prdata                    = prdata_ff;
   assign pready                    = pready_ff;
   assign pslverr                   = pslverr_ff;
   assign freq_cmd                  = freq_ff;
   assign winder_active             = winder_ff;
   assign process_start_freq_enable = sfe_ff;
   assign disp_slot1                = slot1_ff;
   assign disp_slot2                = slot2_ff;
   assign disp_slot3                = slot3_ff;
endmodule

// *** verification/wpid_chk_sva.sv ***
/*
 Port assertions of the winder PID core.
 Assumes a bind from the bench and the core register map header.
*/
`timescale 1ns/10ps
`include "wpid_regs.vh"
module wpid_chk (
   input wire               core_clk,
   input wire               sys_rst,
   input wire               psel,
   input wire               penable,
   input wire               pwrite,
   input wire        [7:0]  paddr,
   input wire        [31:0] pwdata,
   input wire        [31:0] prdata,
   input wire               pready,
   input wire               pslverr,
   input wire signed [15:0] line_speed_in,
   input wire signed [15:0] freq_cmd,
   input wire               winder_active,
   input wire        [4:0]  disp_slot1,
   input wire        [4:0]  disp_slot3
);
   wire commit  = psel && penable && pready;
   wire wr_cfg3 = commit && pwrite && paddr == `WPID_ADDR_CONFIG && pwdata[2:0] == `WPID_CFG_WINDER;
   wire wr_disp = commit && pwrite && paddr == `WPID_ADDR_DISPLAY;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_access_start;
      psel && penable && !$past(penable);
   endsequence
   sequence s_one_wait;
      !pready ##1 pready;
   endsequence

   a_ready_wait: assert property (s_access_start |-> s_one_wait)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_write_zero: assert property (commit && pwrite |-> prdata == 32'h0)
      else $error("prdata not zero on write");
   a_reset_vals: assert property (disable iff (1'b0) sys_rst |=> freq_cmd == 16'sh0000 && !pready
      && !winder_active && disp_slot1 == `WPID_RST_SLOT1 && disp_slot3 == `WPID_RST_SLOT3)
      else $error("outputs not at reset values");
   a_slot_cause: assert property ($changed(disp_slot1) || $changed(disp_slot3) |-> $past(wr_disp))
      else $error("display slot changed without write");
   a_winder_cause: assert property ($rose(winder_active) |-> $past(wr_cfg3, 2))
      else $error("winder mode without config write");
   a_follow_line: assert property ((!winder_active && $stable(line_speed_in))[*6] |-> freq_cmd == line_speed_in)
      else $error("freq_cmd not following line speed");
   a_freq_range: assert property (winder_active && $past(winder_active) |->
      freq_cmd <= `WPID_FS16 && freq_cmd >= -`WPID_FS16)
      else $error("freq_cmd beyond full scale");
endmodule

// *** verification/wpid_host.sv ***
/*
 APB master standing in for the operator panel or fieldbus host.
 Assumes one clock and a slave that answers with pready.
*/
`timescale 1ns/10ps
module wpid_host (
   input  wire         core_clk,
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [7:0]  paddr,
   output logic [31:0] pwdata,
   input  wire  [31:0] prdata,
   input  wire         pready,
   input  wire         pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // Setup, then access held until pready is seen at an edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// *** verification/winder_pid_output_shaping_tb.sv ***
/*
 Self-checking bench of the winder PID core.
 Assumes the host model, the checker and the core register map header.
*/
`timescale 1ns/10ps
`include "wpid_regs.vh"
module winder_pid_output_shaping_tb;
   logic               core_clk      = 1'b0;
   logic               sys_rst       = 1'b1;
   logic signed [15:0] feedback_in   = 16'sh0000;
   logic signed [15:0] line_speed_in = 16'sh0000;
   logic               sample_tick   = 1'b0;
   logic               di17_in       = 1'b0;
   logic               di19_in       = 1'b0;
   wire                psel, penable, pwrite, pready, pslverr, winder_active, start_en;
   wire         [7:0]  paddr;
   wire         [31:0] pwdata, prdata;
   wire signed  [15:0] freq_cmd;
   wire         [4:0]  slot1, slot2, slot3;
   int                 err_count = 0;
   int                 checked   = 0;
   int                 cyc       = 0;

   always #5 core_clk = ~core_clk;

   wpid_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   wpid_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
                  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                  .feedback_in(feedback_in), .line_speed_in(line_speed_in), .sample_tick(sample_tick),
                  .di17_in(di17_in), .di19_in(di19_in), .freq_cmd(freq_cmd), .winder_active(winder_active),
                  .process_start_freq_enable(start_en), .disp_slot1(slot1), .disp_slot2(slot2),
                  .disp_slot3(slot3));

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      host.xfer(a, 1'b1, d, q, e);
      cmp32({31'h0, e}, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      host.xfer(a, 1'b0, 32'h0, q, e);
      cmp32(q, exp);
   endtask

   // Pipeline is five stages deep, so eight cycles settle it
   task automatic chk_freq(input logic signed [15:0] exp);
      repeat (8) @(posedge core_clk);
      cmp32({{16{freq_cmd[15]}}, freq_cmd}, {{16{exp[15]}}, exp});
   endtask

   task automatic pulse;
      @(posedge core_clk);
      sample_tick <= 1'b1;
      @(posedge core_clk);
      sample_tick <= 1'b0;
   endtask

   task automatic t_defaults;
      rd(`WPID_ADDR_CONFIG, 32'h0);
      rd(`WPID_ADDR_DISPLAY, 32'h0007_0000);
      rd(`WPID_ADDR_CLAMP, 32'h2710_2710);
      rd(`WPID_ADDR_GAIN, 32'h2710_2710);
      rd(`WPID_ADDR_DIFUNC, 32'h0000_0107);
   endtask

   task automatic t_display;
      logic [31:0] q;
      logic        e;
      for (int v = 0; v < 32; v++) begin
         wr(`WPID_ADDR_DISPLAY, {11'h0, 5'(v), 3'h0, 5'(31 - v), 3'h0, 5'(v)});
         @(posedge core_clk);
         cmp32({11'h0, slot3, 3'h0, slot2, 3'h0, slot1}, {11'h0, 5'(v), 3'h0, 5'(31 - v), 3'h0, 5'(v)});
      end
      host.xfer(8'h3C, 1'b0, 32'h0, q, e);
      cmp32({31'h0, e}, 32'h1);
      host.xfer(`WPID_ADDR_FREQ, 1'b1, 32'h1, q, e);
      cmp32({31'h0, e}, 32'h1);
   endtask

   task automatic t_config;
      logic [2:0] cur;
      cur = 3'h0;
      for (int c = 0; c < 8; c++) begin
         if (c != 2 && c < 6) cur = 3'(c);
         wr(`WPID_ADDR_CONFIG, 32'(c));
         rd(`WPID_ADDR_CONFIG, {29'h0, cur});
         cmp32({31'h0, winder_active}, {31'h0, cur == `WPID_CFG_WINDER});
      end
      wr(`WPID_ADDR_SETPOINT, 32'h0000_04D2);
      rd(`WPID_ADDR_SETPOINT, 32'h0);
      wr(`WPID_ADDR_WCTRL, 32'h8);
      cmp32({31'h0, start_en}, 32'h0);
   endtask

   task automatic t_bumpless;
      wr(`WPID_ADDR_KGAIN, 32'h0);
      line_speed_in <= 16'sd1000;
      feedback_in <= -16'sd2000;
      chk_freq(16'sd1000);
      wr(`WPID_ADDR_CONFIG, 32'h3);
      repeat (8) begin
         @(posedge core_clk);
         cmp32({{16{freq_cmd[15]}}, freq_cmd}, 32'd1000);
      end
   endtask

   task automatic t_path;
      wr(`WPID_ADDR_WCTRL, 32'h1);
      wr(`WPID_ADDR_KGAIN, 32'h0000_0100);
      chk_freq(16'sd3000);
      wr(`WPID_ADDR_SETPOINT, 32'hFFFF_FE0C);
      chk_freq(16'sd2500);
      wr(`WPID_ADDR_SETPOINT, 32'h0);
      wr(`WPID_ADDR_WCTRL, 32'h2);
      chk_freq(16'sd1000);
      wr(`WPID_ADDR_WCTRL, 32'h4);
      chk_freq(-16'sd1000);
      di19_in <= 1'b1;
      chk_freq(16'sd3000);
      di19_in <= 1'b0;
      wr(`WPID_ADDR_WCTRL, 32'h8);
      repeat (2) @(posedge core_clk);
      cmp32({31'h0, start_en}, 32'h1);
      wr(`WPID_ADDR_WCTRL, 32'h0);
      wr(`WPID_ADDR_CLAMP, 32'h85DC_0000);
      chk_freq(16'sd2500);
      wr(`WPID_ADDR_GAIN, 32'h1388_1388);
      chk_freq(16'sd1750);
      wr(`WPID_ADDR_GAIN, 32'h2710_2710);
      wr(`WPID_ADDR_CLAMP, 32'h0000_81F4);
      feedback_in <= 16'sd2000;
      chk_freq(16'sd500);
      wr(`WPID_ADDR_CLAMP, 32'h0);
      feedback_in <= -16'sd2000;
      wr(`WPID_ADDR_GAIN, 32'h2710_1388);
      wr(`WPID_ADDR_LSRANGE, 32'h07D0_0000);
      chk_freq(16'sd2500);
      wr(`WPID_ADDR_GAIN, 32'h2710_2710);
   endtask

   task automatic t_integ;
      wr(`WPID_ADDR_KGAIN, 32'h0100_0000);
      wr(`WPID_ADDR_WCTRL, 32'h1);
      chk_freq(16'sd1000);
      pulse();
      chk_freq(16'sd3000);
      wr(`WPID_ADDR_WCTRL, 32'h1);
      chk_freq(16'sd1000);
      wr(`WPID_ADDR_DIFUNC, 32'h0000_010D);
      di17_in <= 1'b1;
      pulse();
      chk_freq(16'sd1000);
      di17_in <= 1'b0;
      pulse();
      chk_freq(16'sd3000);
   endtask

   task automatic final_report;
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_defaults();
      t_display();
      t_config();
      t_bumpless();
      t_path();
      t_integ();
      final_report();
   end
endmodule

bind wpid_core wpid_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .line_speed_in(line_speed_in), .freq_cmd(freq_cmd), .winder_active(winder_active),
   .disp_slot1(disp_slot1), .disp_slot3(disp_slot3));
